/* logic/vts_hyst_cmp.sv */
// Step period threshold comparator with hysteresis
`timescale 1ns/1ps
`default_nettype none
module vts_hyst_cmp
	import vts_pkg::*;
#(
	parameter int W = 20
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] period,
	input  wire logic [W-1:0] threshold,
	input  wire logic         small_hyst,
	output logic              fast
);
	initial begin
		if (W < 8) $error("vts_hyst_cmp: W too small");
	end

	logic [W-1:0] shifted;
	logic [W:0]   second;
	logic         enter;
	logic         leave;
	logic         fast_r;
	logic         fast_nxt;

	// Second compare value T - T/16 - 1 (T - T/32 - 1 when small_hyst); negative means never enter
	assign shifted  = small_hyst ? (threshold >> HYST_SHIFT_SMALL) : (threshold >> HYST_SHIFT);
	assign second   = {1'b0, threshold} - {1'b0, shifted} - {{W{1'b0}}, 1'b1}; // see [R15]
	assign enter    = !second[W] && (period <= second[W-1:0]); // see [R16]
	assign leave    = period > threshold; // see [R15]
	assign fast_nxt = fast_r ? !leave : enter;
	assign fast     = fast_r;

	// State held between measurements gives the hysteresis band
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_r <= 1'b0;
		end else if (ce) begin
			fast_r <= fast_nxt;
		end
	end
endmodule
`default_nettype wire

/* logic/vts_mode_switch.sv */
// Velocity threshold mode switch, actual position and register slave
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R01] Hold 20-bit lower speed period threshold
// [R02] Load-adaptive current between both thresholds
// [R03] Arm stop-on-stall below lower threshold
// [R04] Stall to diagnostic outputs below lower
// [R05] Blank stall detection after high crossing
// [R06] High speed disables load-adaptive current
// [R07] High speed disables voltage PWM chopper
// [R08] High speed forces constant off time
// [R09] High speed full step when enabled
// [R10] Signed 32-bit actual position, read/write
// [R11] Position write starts motion in positioning
// [R12] Software changes position only while homing; code accepts writes at any time
// [R13] Features off again below lower speed
// [R14] Measure step period, saturate at all-ones
// [R15] Hysteresis 1/16 or 1/32 of threshold
// [R16] Unsigned compares, update within one clock
module vts_mode_switch
	import vts_pkg::*;
#(
	parameter int ADDR_W       = 12,
	parameter int STEP_W       = 20,
	parameter int BLANK_USTEPS = BLANK_EPERIODS * USTEPS_PER_EPERIOD
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Microstep pulses from the ramp generator, same clock
	input  wire logic              microstep_pulse,
	input  wire logic              microstep_dir,
	// Mode outputs to chopper, stall detector and motion controller
	output logic                   load_current_enable,
	output logic                   stop_on_stall_enable,
	output logic                   diagnostic_outputs_stall,
	output logic                   stall_detect_enable,
	output logic                   voltage_pwm_enable,
	output logic                   chopper_mode,
	output logic [3:0]             fast_decay_time,
	output logic                   full_step_mode,
	output logic                   motion_start,
	output logic                   irq
);
	initial begin
		if (STEP_W != 20) $error("vts_mode_switch: STEP_W must be 20");
		if (ADDR_W < 10) $error("vts_mode_switch: ADDR_W must be at least 10");
		if (BLANK_USTEPS < 1 || BLANK_USTEPS > 65535) $error("vts_mode_switch: bad BLANK_USTEPS");
	end

	localparam logic [STEP_W-1:0] PERIOD_MAX = {STEP_W{1'b1}};
	localparam logic [15:0]       BLANK_LOAD = 16'(BLANK_USTEPS);

	// ********************************************************
	// Byte strobe merge
	// ********************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ********************************************************
	// AXI4-Lite write and read channels
	// ********************************************************
	logic              aw_held_r;
	logic              w_held_r;
	logic [7:0]        aw_idx_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic              aw_take;
	logic              w_take;
	logic              wr_do;
	logic              ar_take;
	logic [7:0]        ar_idx;

	// Readies gated by ce so a frozen block takes nothing
	assign s_axi_awready = ce && !aw_held_r && !bvalid_r;
	assign s_axi_wready  = ce && !w_held_r && !bvalid_r;
	assign s_axi_arready = ce && !rvalid_r;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign wr_do         = ce && aw_held_r && w_held_r && !bvalid_r;
	assign ar_take       = s_axi_arvalid && s_axi_arready;
	assign ar_idx        = s_axi_araddr[9:2];
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// Write target decode
	logic wr_lower;
	logic wr_high;
	logic wr_pos;
	logic wr_cfg;
	logic wr_istat;
	logic wr_imask;
	logic wr_hit;
	assign wr_lower = wr_do && (aw_idx_r == IDX_LOWER_THR);
	assign wr_high  = wr_do && (aw_idx_r == IDX_HIGH_THR);
	assign wr_pos   = wr_do && (aw_idx_r == IDX_ACT_POS);
	assign wr_cfg   = wr_do && (aw_idx_r == IDX_MODE_CFG);
	assign wr_istat = wr_do && (aw_idx_r == IDX_IRQ_STAT);
	assign wr_imask = wr_do && (aw_idx_r == IDX_IRQ_MASK);
	assign wr_hit   = wr_lower || wr_high || wr_pos || wr_cfg || wr_istat || wr_imask;

	// Address and data latch independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_idx_r  <= 8'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end else if (ce) begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_idx_r  <= s_axi_awaddr[9:2];
			end else if (wr_do) begin
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_do) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// Write response; unmapped and read-only targets answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (ce) begin
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ********************************************************
	// Registers
	// ********************************************************
	logic [STEP_W-1:0]  lower_thr_r;
	logic [STEP_W-1:0]  high_thr_r;
	logic [31:0]        act_pos_r;
	logic [CFG_W-1:0]   cfg_r;
	logic [IRQ_W-1:0]   irq_stat_r;
	logic [IRQ_W-1:0]   irq_mask_r;
	logic [IRQ_W-1:0]   irq_event;
	logic [31:0]        pos_merged;
	logic [31:0]        cfg_merged;
	logic [31:0]        mask_merged;
	logic [31:0]        lower_merged;
	logic [31:0]        high_merged;

	assign lower_merged = merge({12'h000, lower_thr_r}, w_data_r, w_strb_r);
	assign high_merged  = merge({12'h000, high_thr_r}, w_data_r, w_strb_r);
	assign pos_merged   = merge(act_pos_r, w_data_r, w_strb_r);
	assign cfg_merged   = merge({19'h00000, cfg_r}, w_data_r, w_strb_r);
	assign mask_merged  = merge({29'h00000000, irq_mask_r}, w_data_r, w_strb_r);

	// Thresholds and configuration; upper bits are not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lower_thr_r <= RST_THR;
			high_thr_r  <= RST_THR;
			cfg_r       <= RST_CFG;
			irq_mask_r  <= RST_IRQ;
		end else if (ce) begin
			if (wr_lower) lower_thr_r <= lower_merged[STEP_W-1:0]; // see [R01]
			if (wr_high) high_thr_r <= high_merged[STEP_W-1:0];
			if (wr_cfg) cfg_r <= cfg_merged[CFG_W-1:0];
			if (wr_imask) irq_mask_r <= mask_merged[IRQ_W-1:0];
		end
	end

	// Software overwrite wins over a microstep in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_pos_r <= RST_POS;
		end else if (ce) begin
			if (wr_pos) begin
				act_pos_r <= pos_merged; // see [R10]
			end else if (microstep_pulse) begin
				act_pos_r <= microstep_dir ? act_pos_r - 32'h00000001 : act_pos_r + 32'h00000001;
			end
		end
	end

	// Start pulse only in positioning mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			motion_start <= 1'b0;
		end else if (ce) begin
			motion_start <= wr_pos && cfg_r[CFG_POS_MODE]; // see [R11]
		end
	end

	// ********************************************************
	// Step period measurement
	// ********************************************************
	logic [STEP_W-1:0] gap_cnt_r;
	logic [STEP_W-1:0] period_r;
	logic              gap_sat;
	assign gap_sat = (gap_cnt_r == PERIOD_MAX);

	// Count cycles between microsteps; standstill reads all-ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_cnt_r <= RST_PERIOD;
			period_r  <= RST_PERIOD;
		end else if (ce) begin
			if (microstep_pulse) begin
				gap_cnt_r <= RST_PERIOD;
				period_r  <= gap_sat ? PERIOD_MAX : gap_cnt_r + 20'h00001; // see [R14]
			end else if (!gap_sat) begin
				gap_cnt_r <= gap_cnt_r + 20'h00001;
				if (gap_cnt_r == PERIOD_MAX - 20'h00001) period_r <= PERIOD_MAX; // see [R14]
			end
		end
	end

	// ********************************************************
	// Threshold comparisons
	// ********************************************************
	logic lower_fast;
	logic high_fast;
	logic high_prev_r;
	logic lower_prev_r;
	logic [15:0] blank_cnt_r;
	logic blanking;

	vts_hyst_cmp #(.W(STEP_W)) u_lower_cmp (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.period     (period_r),
		.threshold  (lower_thr_r),
		.small_hyst (cfg_r[CFG_SMALL_HYST]),
		.fast       (lower_fast)
	);

	vts_hyst_cmp #(.W(STEP_W)) u_high_cmp (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.period     (period_r),
		.threshold  (high_thr_r),
		.small_hyst (cfg_r[CFG_SMALL_HYST]),
		.fast       (high_fast)
	);

	// Any high-threshold crossing reloads the blanking count of microsteps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_prev_r  <= 1'b0;
			lower_prev_r <= 1'b0;
			blank_cnt_r  <= 16'h0000;
		end else if (ce) begin
			high_prev_r  <= high_fast;
			lower_prev_r <= lower_fast;
			if (high_fast != high_prev_r) begin
				blank_cnt_r <= BLANK_LOAD; // see [R05]
			end else if (microstep_pulse && blanking) begin
				blank_cnt_r <= blank_cnt_r - 16'h0001;
			end
		end
	end
	assign blanking = (blank_cnt_r != 16'h0000);

	// Mode outputs are gates of flops, so they follow the comparators
	assign load_current_enable      = cfg_r[CFG_LOAD_CUR_EN] && lower_fast && !high_fast; // see [R02] [R06] [R13]
	assign stop_on_stall_enable     = cfg_r[CFG_STALL_STOP_EN] && lower_fast; // see [R03] [R13]
	assign diagnostic_outputs_stall = cfg_r[CFG_DIAG_STALL_EN] && lower_fast && !blanking; // see [R04] [R13]
	assign stall_detect_enable      = !blanking; // see [R05]
	assign voltage_pwm_enable       = cfg_r[CFG_VPWM_EN] && !high_fast; // see [R07]
	assign chopper_mode             = (high_fast && cfg_r[CFG_HS_CHOP_SW]) ? HS_CHOP_MODE : cfg_r[CFG_CHOP_MODE]; // see [R08]
	assign fast_decay_time          = (high_fast && cfg_r[CFG_HS_CHOP_SW]) ? HS_FD_TIME : cfg_r[CFG_FD_LSB +: 4]; // see [R08]
	assign full_step_mode           = high_fast && cfg_r[CFG_HS_FULLSTEP]; // see [R09]

	// ********************************************************
	// Interrupts
	// ********************************************************
	assign irq_event[IRQ_LOWER_CROSS] = lower_fast != lower_prev_r;
	assign irq_event[IRQ_HIGH_CROSS]  = high_fast != high_prev_r;
	assign irq_event[IRQ_STANDSTILL]  = !microstep_pulse && (gap_cnt_r == PERIOD_MAX - 20'h00001);

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= RST_IRQ;
		end else if (ce) begin
			irq_stat_r <= (irq_stat_r & ~({IRQ_W{wr_istat}} & w_data_r[IRQ_W-1:0])) | irq_event;
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// ********************************************************
	// Read path
	// ********************************************************
	logic [31:0] rd_mux;
	logic        rd_hit;
	logic [31:0] stat_word;
	assign stat_word = {24'h000000, full_step_mode, voltage_pwm_enable, load_current_enable,
		stall_detect_enable, blanking, high_fast, lower_fast, motion_start};
	assign rd_hit = (ar_idx == IDX_STEP_PERIOD) || (ar_idx == IDX_LOWER_THR) ||
		(ar_idx == IDX_HIGH_THR) || (ar_idx == IDX_ACT_POS) || (ar_idx == IDX_MODE_CFG) ||
		(ar_idx == IDX_MODE_STAT) || (ar_idx == IDX_IRQ_STAT) || (ar_idx == IDX_IRQ_MASK);
	assign rd_mux =
		(ar_idx == IDX_STEP_PERIOD) ? {12'h000, period_r} :
		(ar_idx == IDX_LOWER_THR)   ? {12'h000, lower_thr_r} :
		(ar_idx == IDX_HIGH_THR)    ? {12'h000, high_thr_r} :
		(ar_idx == IDX_ACT_POS)     ? act_pos_r :
		(ar_idx == IDX_MODE_CFG)    ? {19'h00000, cfg_r} :
		(ar_idx == IDX_MODE_STAT)   ? stat_word :
		(ar_idx == IDX_IRQ_STAT)    ? {29'h00000000, irq_stat_r} :
		(ar_idx == IDX_IRQ_MASK)    ? {29'h00000000, irq_mask_r} : 32'h00000000;

	// Read data registered; held until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_mux;
				rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* logic/vts_pkg.sv */
// Constants shared by the velocity threshold mode switch and its comparator
`default_nettype none
package vts_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STEP_PERIOD = 8'h49;
	localparam logic [7:0] IDX_LOWER_THR   = 8'h4B;
	localparam logic [7:0] IDX_HIGH_THR    = 8'h4C;
	localparam logic [7:0] IDX_ACT_POS     = 8'h4D;
	localparam logic [7:0] IDX_MODE_CFG    = 8'h60;
	localparam logic [7:0] IDX_MODE_STAT   = 8'h61;
	localparam logic [7:0] IDX_IRQ_STAT    = 8'h62;
	localparam logic [7:0] IDX_IRQ_MASK    = 8'h63;

	// Reset values
	localparam logic [19:0] RST_THR      = 20'h00000;
	localparam logic [31:0] RST_POS      = 32'h00000000;
	localparam logic [19:0] RST_PERIOD   = 20'h00000;
	localparam logic [12:0] RST_CFG      = 13'h0000;
	localparam logic [2:0]  RST_IRQ      = 3'h0;

	// Mode configuration field positions
	localparam int CFG_LOAD_CUR_EN   = 0;
	localparam int CFG_STALL_STOP_EN = 1;
	localparam int CFG_DIAG_STALL_EN = 2;
	localparam int CFG_VPWM_EN       = 3;
	localparam int CFG_HS_CHOP_SW    = 4;
	localparam int CFG_HS_FULLSTEP   = 5;
	localparam int CFG_SMALL_HYST    = 6;
	localparam int CFG_POS_MODE      = 7;
	localparam int CFG_CHOP_MODE     = 8;
	localparam int CFG_FD_LSB        = 9;
	localparam int CFG_W             = 13;

	// Interrupt status bit positions
	localparam int IRQ_LOWER_CROSS = 0;
	localparam int IRQ_HIGH_CROSS  = 1;
	localparam int IRQ_STANDSTILL  = 2;
	localparam int IRQ_W           = 3;

	// Forced chopper setting at high speed
	localparam logic       HS_CHOP_MODE = 1'b1;
	localparam logic [3:0] HS_FD_TIME   = 4'h0;

	// Stall blanking: microsteps per electrical period, periods blanked
	localparam int USTEPS_PER_EPERIOD = 1024;
	localparam int BLANK_EPERIODS     = 2;

	// Hysteresis shifts: 1/16 normally, 1/32 when small
	localparam int HYST_SHIFT       = 4;
	localparam int HYST_SHIFT_SMALL = 5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* sim/test_vts_mode_switch.sv */
// Self-checking bench for the velocity threshold mode switch
`timescale 1ns/1ps
`default_nettype none
module test_vts_mode_switch;
	import vts_pkg::*;
	// ****************************************
	// Signals and design instance
	// ****************************************
	localparam logic [31:0] CFG = 32'h0000143F;
	logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        microstep_pulse = 1'b0, microstep_dir = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd;
	logic        load_current_enable, stop_on_stall_enable, diagnostic_outputs_stall;
	logic        stall_detect_enable, voltage_pwm_enable, chopper_mode, full_step_mode;
	logic        motion_start, irq;
	logic [3:0]  fast_decay_time;
	int          mismatches = 0, n_tests = 0, starts = 0;
	wire  [8:0]  mode_out = {load_current_enable, stop_on_stall_enable, voltage_pwm_enable,
		full_step_mode, chopper_mode, fast_decay_time};

	// Short blanking count keeps the run brief
	vts_mode_switch #(.ADDR_W(12), .STEP_W(20), .BLANK_USTEPS(4)) vts_mode_switch_inst (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.microstep_pulse(microstep_pulse), .microstep_dir(microstep_dir),
		.load_current_enable(load_current_enable), .stop_on_stall_enable(stop_on_stall_enable),
		.diagnostic_outputs_stall(diagnostic_outputs_stall),
		.stall_detect_enable(stall_detect_enable), .voltage_pwm_enable(voltage_pwm_enable),
		.chopper_mode(chopper_mode), .fast_decay_time(fast_decay_time),
		.full_step_mode(full_step_mode), .motion_start(motion_start), .irq(irq));

	// Clock and motion start counter
	always #25 aclk = ~aclk;
	always @(posedge aclk) if (motion_start) starts <= starts + 1;

	// ****************************************
	// Bus, stimulus and compare tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic hang;
		mismatches++;
		test_done;
	endtask

	// Handshakes judged at the falling edge, released after the next rise
	task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		for (int i = 0; i < 50 && !tb; i++) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
		if (!tb) hang;
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, input logic [1:0] er);
		logic ta, tr;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		for (int i = 0; i < 50 && !tr; i++) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
		if (!tr) hang;
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		axi_rd(idx, rd, RESP_OKAY);
		chk(rd, exp);
	endtask

	// Microsteps p cycles apart; ends settled at a falling edge
	task automatic steps(input int p, input int n);
		repeat (n) begin
			repeat (p - 1) @(posedge aclk);
			microstep_pulse <= 1'b1;
			@(posedge aclk);
			microstep_pulse <= 1'b0;
		end
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask

	// Reset values, field widths, read-only and unmapped places
	task automatic reg_check;
		logic [7:0] idx [7] = '{IDX_STEP_PERIOD, IDX_LOWER_THR, IDX_HIGH_THR, IDX_ACT_POS,
			IDX_MODE_CFG, IDX_IRQ_STAT, IDX_IRQ_MASK};
		foreach (idx[i]) rd_chk(idx[i], 32'h00000000);
		rd_chk(IDX_MODE_STAT, 32'h00000010);
		axi_wr(IDX_LOWER_THR, 32'hFFFFFFFF, RESP_OKAY);
		rd_chk(IDX_LOWER_THR, 32'h000FFFFF);
		axi_wr(IDX_HIGH_THR, 32'hFFFFFFFF, RESP_OKAY);
		rd_chk(IDX_HIGH_THR, 32'h000FFFFF);
		axi_wr(IDX_STEP_PERIOD, 32'h12345678, RESP_SLVERR);
		axi_rd(8'h00, rd, RESP_SLVERR);
		chk(rd, 32'h00000000);
	endtask

	// Position wrap, direction, overwrite and motion start
	task automatic pos_check;
		int s0;
		axi_wr(IDX_MODE_CFG, 32'h00000080, RESP_OKAY);
		s0 = starts;
		// Position write in positioning mode starts one motion
		axi_wr(IDX_ACT_POS, 32'h7FFFFFFF, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk(starts - s0, 32'h00000001);
		steps(12'h020, 2);
		rd_chk(IDX_ACT_POS, 32'h80000001);
		@(posedge aclk);
		microstep_dir <= 1'b1;
		steps(12'h020, 3);
		rd_chk(IDX_ACT_POS, 32'h7FFFFFFE);
		axi_wr(IDX_MODE_CFG, 32'h00000000, RESP_OKAY);
		axi_wr(IDX_ACT_POS, 32'hFFFFFFF0, RESP_OKAY);
		repeat (2) @(negedge aclk);
		chk(starts - s0, 32'h00000001);
		rd_chk(IDX_ACT_POS, 32'hFFFFFFF0);
	endtask

	// Threshold crossings, hysteresis, blanking, interrupt, freeze
	task automatic mode_check;
		axi_wr(IDX_LOWER_THR, 32'h00000400, RESP_OKAY);
		axi_wr(IDX_HIGH_THR, 32'h00000100, RESP_OKAY);
		axi_wr(IDX_MODE_CFG, CFG, RESP_OKAY);
		steps(12'h600, 3);
		chk(mode_out, 9'h04A);
		axi_wr(IDX_IRQ_STAT, 32'h00000007, RESP_OKAY);
		rd_chk(IDX_IRQ_STAT, 32'h00000000);
		steps(12'h200, 4);
		chk(mode_out, 9'h1CA);
		chk(diagnostic_outputs_stall, 1'b1);
		rd_chk(IDX_MODE_STAT, 32'h00000072);
		rd_chk(IDX_IRQ_STAT, 32'h00000001);
		chk(irq, 1'b0);
		axi_wr(IDX_IRQ_MASK, 32'h00000001, RESP_OKAY);
		chk(irq, 1'b1);
		axi_wr(IDX_IRQ_STAT, 32'h00000001, RESP_OKAY);
		chk(irq, 1'b0);
		steps(12'h200, 2);
		steps(12'h080, 1);
		chk(mode_out, 9'h0B0);
		chk(diagnostic_outputs_stall, 1'b0);
		rd_chk(IDX_IRQ_STAT, 32'h00000002);
		steps(12'h080, 3);
		chk(stall_detect_enable, 1'b0);
		steps(12'h080, 1);
		chk(stall_detect_enable, 1'b1);
		steps(12'h0F8, 3);
		chk(full_step_mode, 1'b1);
		rd_chk(IDX_STEP_PERIOD, 32'h000000F8);
		// Leave just above the setting, then stay out inside the band
		steps(12'h101, 2);
		chk(full_step_mode, 1'b0);
		steps(12'h0F3, 3);
		chk(full_step_mode, 1'b0);
		axi_wr(IDX_MODE_CFG, CFG | 32'h00000040, RESP_OKAY);
		steps(12'h0F3, 3);
		chk(full_step_mode, 1'b1);
		steps(12'h600, 3);
		chk(mode_out, 9'h04A);
		chk(diagnostic_outputs_stall, 1'b0);
		@(posedge aclk);
		ce <= 1'b0;
		steps(12'h080, 3);
		@(posedge aclk);
		ce <= 1'b1;
		@(negedge aclk);
		chk(mode_out, 9'h04A);
	endtask

	// Reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		reg_check;
		pos_check;
		mode_check;
		test_done;
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge aclk);
		hang;
	end
endmodule
`default_nettype wire

/* sim/vts_mode_switch_checker.sv */
// Port-level assertions for the velocity threshold mode switch
`timescale 1ns/1ps
`default_nettype none
module vts_mode_switch_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       ce,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       microstep_pulse,
	input wire logic       load_current_enable,
	input wire logic       diagnostic_outputs_stall,
	input wire logic       stall_detect_enable,
	input wire logic       voltage_pwm_enable,
	input wire logic       full_step_mode,
	input wire logic       motion_start
);
	// ****************************************
	// Bus answers, mode exclusions, blanking
	// ****************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Both halves held one edge, register and response on the next
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	hold_resp_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	hold_read_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
	hs_current_a: assert property (full_step_mode |-> !load_current_enable)
		else $error("load current active at high speed");
	hs_pwm_a: assert property (full_step_mode |-> !voltage_pwm_enable)
		else $error("voltage chopper active at high speed");
	diag_blank_a: assert property (diagnostic_outputs_stall |-> stall_detect_enable)
		else $error("stall output during blanking");
	blank_end_a: assert property ($rose(stall_detect_enable) |-> $past(microstep_pulse))
		else $error("blanking ended without a microstep");
	start_pulse_a: assert property (motion_start |=> !motion_start)
		else $error("motion start longer than one cycle");
	freeze_a: assert property (
		!ce |=> $stable(full_step_mode) && $stable(stall_detect_enable))
		else $error("mode changed while clock enable low");

	// Main scenarios reached
	start_c: cover property (motion_start);
	hs_c: cover property ($rose(full_step_mode));
	blank_c: cover property ($fell(stall_detect_enable));
endmodule

bind vts_mode_switch vts_mode_switch_checker vts_mode_switch_checker_inst (
	.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.microstep_pulse(microstep_pulse), .load_current_enable(load_current_enable),
	.diagnostic_outputs_stall(diagnostic_outputs_stall),
	.stall_detect_enable(stall_detect_enable), .voltage_pwm_enable(voltage_pwm_enable),
	.full_step_mode(full_step_mode), .motion_start(motion_start)
);
`default_nettype wire
